// >>> wasch_defines.vh
// constants for the wideband acquisition scheduler
// assumes a 200 MHz clock and a byte-addressed control memory port
`ifndef WASCH_DEFINES_VH
`define WASCH_DEFINES_VH
// control memory offsets
`define WASCH_OFS_PERIOD   8'h50
`define WASCH_OFS_OFFSET   8'h52
`define WASCH_OFS_DELAY    8'h54
`define WASCH_OFS_MODE     8'h56
`define WASCH_OFS_BURST    8'h5A
`define WASCH_OFS_XFER     8'h60
// reset values
`define WASCH_RST_PERIOD   16'h0001
`define WASCH_RST_OFFSET   16'h0000
`define WASCH_RST_DELAY    16'h0000
`define WASCH_RST_MODE     8'h00
`define WASCH_RST_BURST    8'h01
`define WASCH_RST_XFER     8'h00
// scheduling modes
`define WASCH_MODE_STOP    8'h00
`define WASCH_MODE_IDLE    8'h01
`define WASCH_MODE_RUN     8'h02
`define WASCH_MODE_BURST   8'h08
`define WASCH_MODE_BURST_ND 8'h09
// highest legal transfer mode method
`define WASCH_XFER_MAX     8'h04
// antenna select codes
`define WASCH_ANT_DIPOLE_X 3'h0
`define WASCH_ANT_MONO_Z   3'h1
`define WASCH_ANT_COIL_X   3'h2
`define WASCH_ANT_DOWNCONV 3'h3
`define WASCH_ANT_PROBE    3'h4
// data set limits in samples
`define WASCH_MAX_SAMPLES  13'h1400
`define WASCH_SYNC_SAMPLES 13'h0800
// timing, in nanoseconds
`define WASCH_CLK_NS       5
`define WASCH_LOW_NS       36000
`define WASCH_HIGH_NS      4500
`endif

// >>> wasch_fifo.v
// sample FIFO with registered read data
// assumes one clock and an active-low asynchronous reset already synchronised
module wasch_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 32,
   parameter AW    = 5
) (
   // clock and reset
   input  wire             clk,
   input  wire             rst_n,
   // fill side
   input  wire             in_valid,
   input  wire [WIDTH-1:0] in_data,
   output wire             in_ready,
   // drain side
   output reg              out_valid,
   output reg  [WIDTH-1:0] out_data,
   input  wire             out_ready
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr;
   reg [AW-1:0]    rd_ptr;
   reg [AW:0]      count;
   wire            push;
   wire            pop;
   localparam [AW:0] FULL = DEPTH[AW:0];

   assign in_ready = (count != FULL);
   assign push     = in_valid && in_ready;
   assign pop      = (count != {(AW+1){1'b0}}) && (!out_valid || out_ready);

   always @(posedge clk) begin
      if (push)
         mem[wr_ptr] <= in_data;
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr    <= {AW{1'b0}};
         rd_ptr    <= {AW{1'b0}};
         count     <= {(AW+1){1'b0}};
         out_valid <= 1'b0;
         out_data  <= {WIDTH{1'b0}};
      end else begin
         if (push)
            wr_ptr <= wr_ptr + 1'b1;
         if (pop) begin
            rd_ptr    <= rd_ptr + 1'b1;
            out_data  <= mem[rd_ptr];
            out_valid <= 1'b1;
         end else if (out_ready) begin
            out_valid <= 1'b0;
         end
         if (push && !pop)
            count <= count + 1'b1;
         else if (pop && !push)
            count <= count - 1'b1;
      end
   end
endmodule // wasch_fifo

// >>> wasch_sample_timer.v
// sample period timer: one strobe per receiver sample period while enabled
// assumes the 200 MHz clock and a synchronised active-low reset
`include "wasch_defines.vh"
module wasch_sample_timer (
   // clock and reset
   input  wire clk,
   input  wire rst_n,
   // control
   input  wire enable,
   input  wire band_high,
   // sample strobe
   output reg  strobe
);
   localparam [31:0] LOW_CYC  = `WASCH_LOW_NS / `WASCH_CLK_NS;
   localparam [31:0] HIGH_CYC = `WASCH_HIGH_NS / `WASCH_CLK_NS;
   reg  [12:0] cnt;
   wire [12:0] reload;

   // low band 36 us, high band 4.5 us
   assign reload = band_high ? (HIGH_CYC[12:0] - 13'h0001) : (LOW_CYC[12:0] - 13'h0001);

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt    <= 13'h0000;
         strobe <= 1'b0;
      end else if (!enable) begin
         cnt    <= reload;
         strobe <= 1'b0;
      end else if (cnt == 13'h0000) begin
         cnt    <= reload;
         strobe <= 1'b1;
      end else begin
         cnt    <= cnt - 13'h0001;
         strobe <= 1'b0;
      end
   end
endmodule // wasch_sample_timer

// >>> wasch_scheduler.v
// wideband acquisition scheduler: control memory, mode machine, schedule and sample path
// assumes tick, trigger, sleep and sample pins are asynchronous; software writes the control memory
//
// Behaviour
// - band sets 36 us or 4.5 us sampling
// - manual/auto gain, eight levels 0 to 70
// - five antennas; downconverter sets extension flag
// - data set never exceeds 5120 samples
// - lowfreq sync forces compression off
// - sync plus high band limits to 2048
// - limits effective only; commanded values kept
// - destination picks low or high rate stream
// - transfer mode byte selects five methods
// - period in ticks; zero means immediate
// - schedule when time mod period equals offset
// - tick delay between successive minipackets
// - mode 0 halts; sleep forces mode 0
// - mode 1 one acquisition per trigger
// - mode 2 acquires continuously on schedule
// - mode 8 bursts count sets, then mode 1
// - burst never restarts by itself
// - 0/1 abort keeps counter; 8/9 reload
// - mode 9 also holds off dust acquisitions
`include "wasch_defines.vh"
module wasch_scheduler (
   // clock and reset
   input  wire        clk,
   input  wire        arst_n,
   // control memory port
   input  wire [7:0]  mem_addr,
   input  wire [15:0] mem_wdata,
   input  wire        mem_wr,
   input  wire        mem_rd,
   output reg  [15:0] mem_rdata,
   // commanded configuration
   input  wire        band_high,
   input  wire [2:0]  antenna_sel,
   input  wire        gain_auto,
   input  wire [2:0]  gain_level,
   input  wire        dest_high,
   input  wire        cmprs_on,
   input  wire        fixed_sample_count_route,
   input  wire [12:0] word_count,
   input  wire        lowfreq_sync,
   // pins from outside
   input  wire        sleep,
   input  wire        realtime_interval_tick,
   input  wire        trigger,
   input  wire [7:0]  sample_data,
   // receiver control outputs
   output reg         band_high_out,
   output reg  [2:0]  antenna_out,
   output reg         gain_auto_out,
   output reg  [6:0]  gain_db,
   output reg         dest_high_out,
   output reg         cmprs_en,
   output reg         fixed_count_out,
   output reg  [12:0] set_size,
   output reg         status_extension_flag,
   output reg  [2:0]  transfer_method,
   output reg         dust_hold,
   output reg         acq_active,
   // sample stream
   output wire        out_valid,
   output wire [7:0]  out_data,
   input  wire        out_ready
);
   localparam [1:0] S_WAIT = 2'h0;
   localparam [1:0] S_ACQ  = 2'h1;
   localparam [1:0] S_GAP  = 2'h2;

   reg        rst_q1;
   reg        rst_n;
   reg  [2:0] tick_s;
   reg  [2:0] trig_s;
   reg  [1:0] sleep_s;
   reg  [7:0] data_q1;
   reg  [7:0] data_q2;

   reg  [15:0] period;
   reg  [15:0] offset;
   reg  [15:0] delay;
   reg  [7:0]  mode;
   reg  [7:0]  burst_count;
   reg  [7:0]  xfer_mode;
   reg  [7:0]  burst_left;
   reg  [15:0] phase;
   reg         sched_pend;
   reg         trig_pend;
   reg  [1:0]  state;
   reg  [12:0] samples_left;
   reg  [15:0] gap_left;

   wire        tick;
   wire        trig_edge;
   wire        sleeping;
   wire        wr_mode;
   wire        is_burst;
   wire        sched_go;
   wire        start;
   wire        strobe;
   wire        fifo_ready;
   wire        push;
   wire        set_done;
   wire [15:0] next_phase;
   wire [12:0] capped;
   wire [12:0] eff_count;

   // reset release through two flops
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_q1 <= 1'b0;
         rst_n  <= 1'b0;
      end else begin
         rst_q1 <= 1'b1;
         rst_n  <= rst_q1;
      end
   end

   // pin synchronisers
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_s  <= 3'h0;
         trig_s  <= 3'h0;
         sleep_s <= 2'h0;
         data_q1 <= 8'h00;
         data_q2 <= 8'h00;
      end else begin
         tick_s  <= {tick_s[1:0], realtime_interval_tick};
         trig_s  <= {trig_s[1:0], trigger};
         sleep_s <= {sleep_s[0], sleep};
         data_q1 <= sample_data;
         data_q2 <= data_q1;
      end
   end

   assign tick      = tick_s[1] && !tick_s[2];
   assign trig_edge = trig_s[1] && !trig_s[2];
   assign sleeping  = sleep_s[1];
   assign wr_mode   = mem_wr && (mem_addr == `WASCH_OFS_MODE);
   assign is_burst  = (mode == `WASCH_MODE_BURST) || (mode == `WASCH_MODE_BURST_ND);

   // effective data set size
   assign capped    = (word_count > `WASCH_MAX_SAMPLES) ? `WASCH_MAX_SAMPLES : word_count;
   assign eff_count = (lowfreq_sync && band_high && capped > `WASCH_SYNC_SAMPLES) ?
                      `WASCH_SYNC_SAMPLES : capped;

   // control memory writes
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         period      <= `WASCH_RST_PERIOD;
         offset      <= `WASCH_RST_OFFSET;
         delay       <= `WASCH_RST_DELAY;
         burst_count <= `WASCH_RST_BURST;
         xfer_mode   <= `WASCH_RST_XFER;
      end else if (mem_wr) begin
         case (mem_addr)
            `WASCH_OFS_PERIOD: period      <= mem_wdata;
            `WASCH_OFS_OFFSET: offset      <= mem_wdata;
            `WASCH_OFS_DELAY:  delay       <= mem_wdata;
            `WASCH_OFS_BURST:  burst_count <= mem_wdata[7:0];
            `WASCH_OFS_XFER:   xfer_mode   <= mem_wdata[7:0];
            default: ;
         endcase
      end
   end

   // control memory reads, one cycle later
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_rdata <= 16'h0000;
      end else if (mem_rd) begin
         case (mem_addr)
            `WASCH_OFS_PERIOD: mem_rdata <= period;
            `WASCH_OFS_OFFSET: mem_rdata <= offset;
            `WASCH_OFS_DELAY:  mem_rdata <= delay;
            `WASCH_OFS_MODE:   mem_rdata <= {8'h00, mode};
            `WASCH_OFS_BURST:  mem_rdata <= {8'h00, burst_count};
            `WASCH_OFS_XFER:   mem_rdata <= {8'h00, xfer_mode};
            default:           mem_rdata <= 16'h0000;
         endcase
      end
   end

   // tick phase: system time modulo the period
   assign next_phase = (phase + 16'h0001 >= period) ? 16'h0000 : phase + 16'h0001;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase      <= 16'h0000;
         sched_pend <= 1'b0;
      end else if (tick) begin
         phase      <= next_phase;
         // a hit books the following tick period
         sched_pend <= (period != 16'h0000) && (phase == offset);
      end
   end

   // zero period schedules at once, otherwise at the booked tick
   assign sched_go = (period == 16'h0000) ? 1'b1 : (sched_pend && tick);

   // idle trigger latch; a trigger in the clearing cycle still counts
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         trig_pend <= 1'b0;
      else if (mode != `WASCH_MODE_IDLE || sleeping)
         trig_pend <= 1'b0;
      else if (trig_edge)
         trig_pend <= 1'b1;
      else if (start)
         trig_pend <= 1'b0;
   end

   assign start = (state == S_WAIT) && !sleeping && (
                  ((mode == `WASCH_MODE_IDLE) && trig_pend) ||
                  ((mode == `WASCH_MODE_RUN) && sched_go) ||
                  (is_burst && (burst_left != 8'h00) && sched_go));

   assign push     = strobe && fifo_ready;
   assign set_done = (state == S_ACQ) && push && (samples_left == 13'h0001);

   // acquisition sequencer
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state        <= S_WAIT;
         samples_left <= 13'h0000;
         gap_left     <= 16'h0000;
      end else begin
         case (state)
            S_WAIT: begin
               if (start) begin
                  state        <= (eff_count == 13'h0000) ? S_WAIT : S_ACQ;
                  samples_left <= eff_count;
               end
            end
            S_ACQ: begin
               if (sleeping || mode == `WASCH_MODE_STOP) begin
                  state <= S_WAIT;
               end else if (push) begin
                  samples_left <= samples_left - 13'h0001;
                  if (samples_left == 13'h0001) begin
                     gap_left <= delay;
                     state    <= (delay == 16'h0000) ? S_WAIT : S_GAP;
                  end
               end
            end
            S_GAP: begin
               if (tick) begin
                  gap_left <= gap_left - 16'h0001;
                  if (gap_left == 16'h0001)
                     state <= S_WAIT;
               end
            end
            default: state <= S_WAIT;
         endcase
      end
   end

   // scheduling mode and burst counter
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode       <= `WASCH_RST_MODE;
         burst_left <= 8'h00;
      end else if (sleeping) begin
         mode <= `WASCH_MODE_STOP;
      end else if (wr_mode) begin
         mode <= mem_wdata[7:0];
         // 8 or 9 reload and start afresh, 0 or 1 leave the counter alone
         if (mem_wdata[7:0] == `WASCH_MODE_BURST || mem_wdata[7:0] == `WASCH_MODE_BURST_ND)
            burst_left <= burst_count;
      end else if (is_burst) begin
         if (set_done)
            burst_left <= burst_left - 8'h01;
         // back to idle only; a new burst needs a fresh mode write
         if (burst_left == 8'h00 || (set_done && burst_left == 8'h01))
            mode <= `WASCH_MODE_IDLE;
      end
   end

   // registered receiver controls
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         band_high_out         <= 1'b0;
         antenna_out           <= `WASCH_ANT_DIPOLE_X;
         gain_auto_out         <= 1'b0;
         gain_db               <= 7'h00;
         dest_high_out         <= 1'b0;
         cmprs_en              <= 1'b0;
         fixed_count_out       <= 1'b0;
         set_size              <= 13'h0000;
         status_extension_flag <= 1'b0;
         transfer_method       <= 3'h0;
         dust_hold             <= 1'b0;
         acq_active            <= 1'b0;
      end else begin
         band_high_out         <= band_high;
         antenna_out           <= (antenna_sel > `WASCH_ANT_PROBE) ? `WASCH_ANT_DIPOLE_X : antenna_sel;
         gain_auto_out         <= gain_auto;
         gain_db               <= {1'b0, gain_level, 3'h0} + {3'h0, gain_level, 1'b0};
         dest_high_out         <= dest_high;
         cmprs_en              <= cmprs_on && !lowfreq_sync;
         fixed_count_out       <= fixed_sample_count_route;
         set_size              <= eff_count;
         status_extension_flag <= (antenna_sel == `WASCH_ANT_DOWNCONV);
         transfer_method       <= (xfer_mode > `WASCH_XFER_MAX) ? 3'h0 : xfer_mode[2:0];
         dust_hold             <= (mode == `WASCH_MODE_BURST_ND);
         acq_active            <= (state == S_ACQ);
      end
   end

   // sample timing runs only while the FIFO can take a sample
   wasch_sample_timer u_timer (
      .clk       (clk),
      .rst_n     (rst_n),
      .enable    ((state == S_ACQ) && fifo_ready),
      .band_high (band_high),
      .strobe    (strobe)
   );

   wasch_fifo #(
      .WIDTH (8),
      .DEPTH (32),
      .AW    (5)
   ) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (push),
      .in_data   (data_q2),
      .in_ready  (fifo_ready),
      .out_valid (out_valid),
      .out_data  (out_data),
      .out_ready (out_ready)
   );
endmodule // wasch_scheduler

// >>> wasch_monitor.sv
// checker for the acquisition scheduler, watching top-level ports only
// bound to wasch_scheduler; one clock, active-low asynchronous reset
module wasch_monitor (
   // clock, reset and memory port
   input wire        clk,
   input wire        arst_n,
   input wire [7:0]  mem_addr,
   input wire [15:0] mem_wdata,
   input wire        mem_wr,
   // commanded configuration
   input wire        band_high,
   input wire [2:0]  antenna_sel,
   input wire [2:0]  gain_level,
   input wire        dest_high,
   input wire        cmprs_on,
   input wire [12:0] word_count,
   input wire        lowfreq_sync,
   input wire        sleep,
   // watched outputs
   input wire        band_high_out,
   input wire [6:0]  gain_db,
   input wire        dest_high_out,
   input wire        cmprs_en,
   input wire [12:0] set_size,
   input wire        status_extension_flag,
   input wire [2:0]  transfer_method,
   input wire        dust_hold,
   input wire        acq_active
);
   timeunit 1ns;
   timeprecision 1ps;
   reg  [2:0]  up;
   reg  [12:0] exp_size;
   wire        rdy = up > 3'h4;
   wire        w9  = mem_wr && mem_addr == 8'h56 && mem_wdata[7:0] == 8'h09;
   // cycles since reset release
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         up <= 3'h0;
      else if (up != 3'h7)
         up <= up + 3'h1;
   end
   always @(posedge clk) exp_size <= (word_count > 13'h1400) ? 13'h1400 : word_count;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   property p_band; rdy |-> band_high_out == $past(band_high); endproperty
   a_band: assert property (p_band) else $error("band output wrong");
   property p_gain; rdy |-> gain_db == $past(gain_level) * 7'd10; endproperty
   a_gain: assert property (p_gain) else $error("gain level wrong");
   property p_flag; rdy |-> status_extension_flag == ($past(antenna_sel) == 3'h3); endproperty
   a_flag: assert property (p_flag) else $error("extension flag wrong");
   property p_max; set_size <= 13'h1400; endproperty
   a_max: assert property (p_max) else $error("set size above maximum");
   property p_cmprs; rdy |-> cmprs_en == ($past(cmprs_on) && !$past(lowfreq_sync)); endproperty
   a_cmprs: assert property (p_cmprs) else $error("compression enable wrong");
   property p_sync; rdy && $past(lowfreq_sync) && $past(band_high) |-> set_size <= 13'h0800; endproperty
   a_sync: assert property (p_sync) else $error("sync set size too big");
   property p_size; rdy && !($past(lowfreq_sync) && $past(band_high)) |-> set_size == exp_size; endproperty
   a_size: assert property (p_size) else $error("effective size wrong");
   property p_dest; rdy |-> dest_high_out == $past(dest_high); endproperty
   a_dest: assert property (p_dest) else $error("destination wrong");
   property p_xfer; transfer_method <= 3'h4; endproperty
   a_xfer: assert property (p_xfer) else $error("transfer method out of range");
   property p_sleep; sleep [*5] |=> !acq_active && !dust_hold; endproperty
   a_sleep: assert property (p_sleep) else $error("active while asleep");
   property p_dust; $rose(dust_hold) |-> $past(w9) || $past(w9, 2); endproperty
   a_dust: assert property (p_dust) else $error("dust hold without mode write");
   property p_quiet; $rose(arst_n) |-> !acq_active [*4]; endproperty
   a_quiet: assert property (p_quiet) else $error("active after reset");
   c_acq: cover property ($rose(acq_active));
   c_dust: cover property ($rose(dust_hold));
   c_sync: cover property (rdy && lowfreq_sync && band_high && set_size == 13'h0800);
endmodule // wasch_monitor
bind wasch_scheduler wasch_monitor wasch_monitor_inst (
   .clk, .arst_n, .mem_addr, .mem_wdata, .mem_wr, .band_high, .antenna_sel, .gain_level, .dest_high, .cmprs_on,
   .word_count, .lowfreq_sync, .sleep, .band_high_out, .gain_db, .dest_high_out, .cmprs_en, .set_size,
   .status_extension_flag, .transfer_method, .dust_hold, .acq_active);

// >>> wasch_partner.sv
// far side model: tick source, sample source and stream sink
// same clock as the scheduler; stall holds the sink off
module wasch_partner #(
   parameter int         TICK_P = 1500,
   parameter logic [7:0] SAMPLE = 8'hC3
) (
   input  wire        clk,
   input  wire        run_tick,
   input  wire        stall,
   output logic       tick,
   output logic [7:0] sample_data,
   input  wire        out_valid,
   input  wire [7:0]  out_data,
   output logic       out_ready,
   output int         rx_count,
   output int         rx_bad,
   output int         rx_gap
);
   timeunit 1ns;
   timeprecision 1ps;
   int cyc = 0, last = 0;
   initial {rx_count, rx_bad, rx_gap} = 96'h0;
   assign sample_data = SAMPLE;
   assign out_ready = !stall;
   // four-cycle tick pulse
   assign tick = run_tick && (cyc % TICK_P) < 4;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (out_valid && out_ready) begin
         rx_count <= rx_count + 1;
         rx_gap <= cyc - last;
         last <= cyc;
         if (out_data !== SAMPLE)
            rx_bad <= rx_bad + 1;
      end
   end
endmodule // wasch_partner

// >>> wasch_scheduler_test.sv
// testbench for the acquisition scheduler
// drives inputs at the falling edge; partner supplies ticks, samples and sink
module wasch_scheduler_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TICK_P = 1500;
   logic        clk, arst_n, mem_wr, mem_rd, band_high, gain_auto, dest_high, cmprs_on, fixed_route;
   logic        lowfreq_sync, sleep, trigger, run_tick, stall, acq_q, tick, out_valid, out_ready;
   logic        band_high_out, gain_auto_out, dest_high_out, cmprs_en, fixed_count_out, flag;
   logic        dust_hold, acq_active;
   logic [7:0]  mem_addr, sample_data, out_data;
   logic [15:0] mem_wdata, mem_rdata;
   logic [2:0]  antenna_sel, gain_level, antenna_out, transfer_method;
   logic [12:0] word_count, set_size;
   logic [6:0]  gain_db;
   int          bad_count = 0, cmp_count = 0, sets = 0, gap = 0, last_gap = 0, cycles = 0;
   int          rx_count, rx_bad, rx_gap, j, base;
   wasch_scheduler wasch_scheduler_inst (
      .clk, .arst_n, .mem_addr, .mem_wdata, .mem_wr, .mem_rd, .mem_rdata, .band_high, .antenna_sel, .gain_auto,
      .gain_level, .dest_high, .cmprs_on, .fixed_sample_count_route(fixed_route), .word_count, .lowfreq_sync,
      .sleep, .realtime_interval_tick(tick), .trigger, .sample_data, .band_high_out, .antenna_out, .gain_auto_out,
      .gain_db, .dest_high_out, .cmprs_en, .fixed_count_out, .set_size, .status_extension_flag(flag),
      .transfer_method, .dust_hold, .acq_active, .out_valid, .out_data, .out_ready);
   wasch_partner #(.TICK_P(TICK_P)) wasch_partner_inst (
      .clk, .run_tick, .stall, .tick, .sample_data, .out_valid, .out_data, .out_ready, .rx_count, .rx_bad, .rx_gap);
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // count acquisitions and the idle gap before each one
   always @(posedge clk) begin
      acq_q <= acq_active;
      gap <= acq_active ? 0 : gap + 1;
      if (acq_active === 1'b1 && acq_q === 1'b0) begin
         sets <= sets + 1;
         last_gap <= gap;
      end
      cycles <= cycles + 1;
      if (cycles == 96000) begin
         bad_count++;
         finish_test();
      end
   end
   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge clk);
      mem_addr = a;
      mem_wdata = d;
      mem_wr = 1'b1;
      @(negedge clk);
      mem_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string name);
      @(negedge clk);
      mem_addr = a;
      mem_rd = 1'b1;
      @(negedge clk);
      mem_rd = 1'b0;
      @(posedge clk);
      #1 check(name, exp, mem_rdata);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic pulse();
      @(negedge clk);
      trigger = 1'b1;
      repeat (4) @(negedge clk);
      trigger = 1'b0;
   endtask
   task automatic wait_sets(input int n, input int lim);
      int k;
      for (k = 0; k < lim && !(sets >= n && acq_active === 1'b0); k++) @(posedge clk);
      #1 check("sets", 16'(n), 16'(sets));
   endtask
   task automatic finish_test();
      $display("counts: %0d compares, %0d mismatches", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      {arst_n, mem_wr, mem_rd, band_high, gain_auto, dest_high, cmprs_on, fixed_route} = 8'h00;
      {lowfreq_sync, sleep, trigger, run_tick, stall, acq_q} = 6'h00;
      mem_addr = 8'h00;
      mem_wdata = 16'h0000;
      antenna_sel = 3'h0;
      gain_level = 3'h0;
      word_count = 13'h0001;
      repeat (3) @(negedge clk);
      arst_n = 1'b1;
      settle(4);
      rd(8'h50, 16'h0001, "period");
      rd(8'h52, 16'h0000, "offset");
      rd(8'h54, 16'h0000, "delay");
      rd(8'h56, 16'h0000, "mode");
      rd(8'h5A, 16'h0001, "burst");
      rd(8'h70, 16'h0000, "unmapped");
      wr(8'h70, 16'hBEEF);
      wr(8'h52, 16'hA55A);
      rd(8'h52, 16'hA55A, "offset");
      for (j = 0; j < 6; j++) begin
         wr(8'h60, 16'(j));
         settle(2);
         check("method", (j > 4) ? 16'h0000 : 16'(j), 16'(transfer_method));
      end
      $display("test registers done");
      for (j = 0; j < 8; j++) begin
         @(negedge clk);
         {dest_high, gain_auto, band_high} = 3'(j);
         antenna_sel = 3'(j);
         gain_level = 3'(j);
         fixed_route = j[0];
         settle(2);
         check("band", 16'(j & 1), 16'(band_high_out));
         check("gain", 16'(j * 10), 16'(gain_db));
         check("auto", 16'((j >> 1) & 1), 16'(gain_auto_out));
         check("antenna", (j > 4) ? 16'h0000 : 16'(j), 16'(antenna_out));
         check("flag", 16'(j == 3), 16'(flag));
         check("dest", 16'(j >> 2), 16'(dest_high_out));
         check("route", 16'(j & 1), 16'(fixed_count_out));
      end
      $display("test configuration done");
      @(negedge clk);
      {band_high, cmprs_on, fixed_route, lowfreq_sync} = 4'hC;
      word_count = 13'h1000;
      for (j = 0; j < 3; j++) begin
         @(negedge clk);
         lowfreq_sync = (j == 1);
         settle(2);
         check("size", (j == 1) ? 16'h0800 : 16'h1000, 16'(set_size));
         check("cmprs", 16'(j != 1), 16'(cmprs_en));
      end
      @(negedge clk);
      word_count = 13'h1FFF;
      settle(2);
      check("size", 16'h1400, 16'(set_size));
      @(negedge clk);
      cmprs_on = 1'b0;
      word_count = 13'd40;
      $display("test limits done");
      pulse();
      settle(2000);
      check("sets", 16'h0000, 16'(sets));
      @(negedge clk) stall = 1'b1;
      wr(8'h56, 16'h0001);
      pulse();
      settle(30500);
      check("valid", 16'h0001, 16'(out_valid));
      check("held", 16'h0001, 16'(acq_active));
      check("rx", 16'h0000, 16'(rx_count));
      @(negedge clk);
      stall = 1'b0;
      wait_sets(1, 15000);
      settle(50);
      check("rx", 16'd40, 16'(rx_count));
      check("data", 16'h0000, 16'(rx_bad));
      settle(3000);
      check("sets", 16'h0001, 16'(sets));
      $display("test idle done");
      @(negedge clk);
      word_count = 13'd2;
      run_tick = 1'b1;
      wr(8'h54, 16'h0002);
      wr(8'h50, 16'h0000);
      wr(8'h5A, 16'h0002);
      base = sets;
      wr(8'h56, 16'h0008);
      wait_sets(base + 2, 20000);
      rd(8'h56, 16'h0001, "mode");
      check("sample", 16'd900, 16'(rx_gap));
      check("gap", 16'h0001, 16'(last_gap >= TICK_P));
      settle(4000);
      check("sets", 16'(base + 2), 16'(sets));
      wr(8'h5A, 16'h0003);
      wr(8'h56, 16'h0009);
      settle(10);
      check("dust", 16'h0001, 16'(dust_hold));
      wr(8'h56, 16'h0001);
      settle(4000);
      check("dust", 16'h0000, 16'(dust_hold));
      check("sets", 16'(base + 3), 16'(sets));
      check("active", 16'h0000, 16'(acq_active));
      $display("test burst done");
      wr(8'h52, 16'h0001);
      wr(8'h50, 16'h0003);
      wr(8'h54, 16'h0000);
      wr(8'h56, 16'h0002);
      settle(2 * TICK_P);
      base = sets;
      settle(9 * TICK_P);
      check("sets", 16'(base + 3), 16'(sets));
      $display("test run done");
      wr(8'h50, 16'h0000);
      settle(TICK_P + 20);
      check("active", 16'h0001, 16'(acq_active));
      @(negedge clk);
      sleep = 1'b1;
      settle(20);
      check("active", 16'h0000, 16'(acq_active));
      rd(8'h56, 16'h0000, "mode");
      wr(8'h56, 16'h0002);
      rd(8'h56, 16'h0000, "mode");
      @(negedge clk);
      sleep = 1'b0;
      base = sets;
      settle(3000);
      check("sets", 16'(base), 16'(sets));
      $display("test sleep done");
      finish_test();
   end
endmodule // wasch_scheduler_test
